// *** core/tfc_config.sv ***
/*
 * device_configuration register bank of a remote diode temperature
 * monitor with fan control: alert masking, hold mode with single
 * conversions, fan output gating, shared alert/tach pin, one-time
 * critical limit reprogramming and the remote fault filter.
 * assumes a conversion engine outside that pulses conv_done with the
 * remote result, a fan waveform generator feeding fan_wave, and a
 * register port master that never issues read and write together.
 */
// Strobed register access was left to the implementer.
// Summary of operation
// R01: config bit 7 set masks alerts and keeps the alert pin released.
// R02: config bit 6 clear keeps conversions, comparisons and fan running.
// R03: config bit 6 set enters hold; back-to-back conversions stop.
// R04: in hold, any write to 0x0F starts one conversion and compare.
// R05: bit 5 clear keeps the present fan waveform during hold.
// R06: bit 5 set in hold forces fan output to polarity's disabled level.
// R07: config bits 4 and 3 are unused and read as zero.
// R08: bit 2 picks shared pin: 0 open-drain alert, 1 tach input.
// R09: with pin as tach input, no alert is ever driven on it.
// R10: critical limit comes out of power-up at 85 degrees.
// R11: critical limit changes once, after bit 1 set, by writing 0x19.
// R12: after one change, the critical limit rejects all further writes.
// R13: bit 0 clear: any one remote result outside setpoints alerts.
// R14: bit 0 set: alert only after three consecutive outside results.
// R15: an in-range remote result restarts the consecutive count.
`timescale 1ns/1ps
`default_nettype none
module tfc_config (
   input wire logic clk,
   input wire logic rst_b,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // conversion engine
   input wire logic conv_done,
   input wire logic [7:0] remote_temp,
   output logic conv_run,
   output logic conv_single,
   // fan modulation
   input wire logic fan_wave,
   output logic fan_out,
   // shared alert / tach pin
   input wire logic alert_tach_in,
   output logic alert_tach_out,
   output logic alert_tach_oe,
   output logic tach_pulse_in,
   // status levels
   output logic crit_over,
   output logic irq
);
   import tfc_pkg::*;

   // signed compare, used for setpoints and the critical limit
   function automatic logic tfc_above(input logic [7:0] a,
                                       input logic [7:0] b);
      tfc_above = $signed(a) > $signed(b);
   endfunction

   logic [7:0] config_reg;
   logic [7:0] crit_limit;
   logic crit_locked;
   logic [7:0] high_setpoint;
   logic [7:0] low_setpoint;
   logic [7:0] fan_control;
   logic [TFC_IRQ_WIDTH-1:0] irq_status;
   logic [TFC_IRQ_WIDTH-1:0] irq_enable;
   logic fault;
   logic fault_seen;

   // address decode
   wire logic sel_config = (reg_addr == TFC_ADDR_CONFIG) ||
      (reg_addr == TFC_ADDR_CONFIG_ALT);
   wire logic sel_one_shot = reg_addr == TFC_ADDR_ONE_SHOT;
   wire logic sel_crit = reg_addr == TFC_ADDR_CRIT_LIMIT;
   wire logic sel_high = reg_addr == TFC_ADDR_HIGH_SETPOINT;
   wire logic sel_low = reg_addr == TFC_ADDR_LOW_SETPOINT;
   wire logic sel_fan = reg_addr == TFC_ADDR_FAN_CONTROL;
   wire logic sel_status = reg_addr == TFC_ADDR_IRQ_STATUS;
   wire logic sel_enable = reg_addr == TFC_ADDR_IRQ_ENABLE;
   wire logic sel_clear = reg_addr == TFC_ADDR_IRQ_CLEAR;

   // configuration fields
   wire logic alert_mask = config_reg[TFC_CFG_ALERT_MASK];
   wire logic hold_mode = config_reg[TFC_CFG_HOLD];
   wire logic fan_off_in_hold = config_reg[TFC_CFG_FAN_OFF_IN_HOLD];
   wire logic tach_select = config_reg[TFC_CFG_TACH_SELECT];
   wire logic crit_unlock = config_reg[TFC_CFG_CRIT_UNLOCK];
   wire logic filter_three = config_reg[TFC_CFG_FAULT_FILTER];
   wire logic fan_polarity = fan_control[TFC_FAN_POLARITY];

   // write strobes
   wire logic wr_config = reg_write && sel_config;
   wire logic wr_crit = reg_write && sel_crit;
   // the critical limit only takes a write when unlocked and never used
   wire logic crit_accept = wr_crit && crit_unlock && !crit_locked; // see R11
   wire logic one_shot_req = reg_write && sel_one_shot && hold_mode; // see R04
   wire logic wr_clear = reg_write && sel_clear;

   // remote result checks, valid in the cycle of conv_done
   wire logic out_of_limit = tfc_above(remote_temp, high_setpoint) ||
      tfc_above(low_setpoint, remote_temp);
   wire logic crit_hit = tfc_above(remote_temp, crit_limit);

   // interrupt events
   wire logic fault_rise = fault && !fault_seen;
   wire logic [TFC_IRQ_WIDTH-1:0] irq_events = {crit_accept,
      conv_done && crit_hit, fault_rise, conv_done};
   wire logic [TFC_IRQ_WIDTH-1:0] irq_clear_bits =
      wr_clear ? reg_wdata[TFC_IRQ_WIDTH-1:0] : '0;
   // an event in the clearing cycle survives the clear
   wire logic [TFC_IRQ_WIDTH-1:0] next_irq_status =
      (irq_status & ~irq_clear_bits) | irq_events;

   // pin and fan output decisions
   // alert is dropped when masked or when the pin listens to the fan tach
   wire logic next_alert_oe = fault && !alert_mask && !tach_select; // see R01 R08 R09
   // disabled level is the inactive level chosen by polarity
   wire logic fan_disabled_level = fan_polarity;
   wire logic next_fan_out = (hold_mode && fan_off_in_hold) ?
      fan_disabled_level : fan_wave; // see R05 R06
   wire logic next_crit_over = conv_done ? crit_hit : crit_over;

   // read mux, unmapped offsets read as zero
   wire logic [7:0] next_rdata =
      sel_config ? (config_reg & TFC_CFG_WRITABLE) : // see R07
      sel_crit ? crit_limit :
      sel_high ? high_setpoint :
      sel_low ? low_setpoint :
      sel_fan ? fan_control :
      sel_status ? {{(8-TFC_IRQ_WIDTH){1'b0}}, irq_status} :
      sel_enable ? {{(8-TFC_IRQ_WIDTH){1'b0}}, irq_enable} :
      TFC_READ_ZERO;

   // configuration and setpoint registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         config_reg <= TFC_CONFIG_RESET;
         high_setpoint <= TFC_HIGH_SETPOINT_RESET;
         low_setpoint <= TFC_LOW_SETPOINT_RESET;
         fan_control <= TFC_FAN_CONTROL_RESET;
         irq_enable <= '0;
      end else if (reg_write) begin
         if (sel_config) begin
            config_reg <= reg_wdata & TFC_CFG_WRITABLE; // see R07
         end
         if (sel_high) begin
            high_setpoint <= reg_wdata;
         end
         if (sel_low) begin
            low_setpoint <= reg_wdata;
         end
         if (sel_fan) begin
            fan_control <= reg_wdata;
         end
         if (sel_enable) begin
            irq_enable <= reg_wdata[TFC_IRQ_WIDTH-1:0];
         end
      end
   end

   // critical limit: reset value at power-up, one change, then frozen
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         crit_limit <= TFC_CRIT_LIMIT_RESET; // see R10
         crit_locked <= 1'b0;
      end else if (crit_accept) begin
         crit_limit <= reg_wdata; // see R11
         crit_locked <= 1'b1; // see R12
      end
   end

   // conversion control: continuous unless held, single shots in hold
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         conv_run <= 1'b1;
         conv_single <= 1'b0;
      end else begin
         conv_run <= !hold_mode; // see R02 R03
         conv_single <= one_shot_req; // see R04
      end
   end

   // pins, fan output and status
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         alert_tach_oe <= 1'b0;
         alert_tach_out <= 1'b0;
         tach_pulse_in <= 1'b0;
         fan_out <= 1'b0;
         crit_over <= 1'b0;
         fault_seen <= 1'b0;
      end else begin
         alert_tach_oe <= next_alert_oe;
         alert_tach_out <= 1'b0; // open drain only ever pulls low
         tach_pulse_in <= tach_select && alert_tach_in; // see R08
         fan_out <= next_fan_out;
         crit_over <= next_crit_over;
         fault_seen <= fault;
      end
   end

   // interrupt status, level irq and read data
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_status <= '0;
         irq <= 1'b0;
         reg_rdata <= TFC_READ_ZERO;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_enable);
         reg_rdata <= reg_read ? next_rdata : TFC_READ_ZERO;
      end
   end

   // remote fault filter; it keeps counting even while alerts are masked
   tfc_fault_filter u_remote_fault_filter (
      .clk(clk),
      .rst_b(rst_b),
      .result_valid(conv_done),
      .out_of_limit(out_of_limit),
      .three_mode(filter_three), // see R13 R14
      .fault(fault)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_mask_release: assert property (alert_mask |=> !alert_tach_oe) // see R01
      else $error("alert driven while masked");
   a_tach_no_alert: assert property (tach_select |=> !alert_tach_oe) // see R09
      else $error("alert driven while pin is tach input");
   a_alert_follow: assert property ( // see R08
      fault && !alert_mask && !tach_select |=> alert_tach_oe)
      else $error("enabled alert not driven");
   a_run_level: assert property ( // see R02 R03
      1 |=> conv_run == !$past(hold_mode))
      else $error("conversion run level wrong");
   // a back-to-back shot legally keeps the pulse up one more cycle
   a_one_shot: assert property ( // see R04
      reg_write && sel_one_shot && hold_mode
      |=> conv_single ##1 conv_single == $past(one_shot_req))
      else $error("single conversion not pulsed once");
   a_no_shot_run: assert property (conv_single |-> $past(hold_mode)) // see R04
      else $error("single conversion outside hold");
   a_fan_keep: assert property ( // see R02 R05
      !(hold_mode && fan_off_in_hold) |=> fan_out == $past(fan_wave))
      else $error("fan output does not follow waveform");
   a_fan_off: assert property ( // see R06
      hold_mode && fan_off_in_hold |=> fan_out == $past(fan_polarity))
      else $error("fan output not at disabled level");
   a_unused_zero: assert property ( // see R07
      reg_read && sel_config |=> reg_rdata[4:3] == 2'h0)
      else $error("unused config bits read nonzero");
   a_crit_take: assert property ( // see R11
      crit_accept |=> crit_locked && crit_limit == $past(reg_wdata))
      else $error("critical limit write not taken");
   a_crit_frozen: assert property ( // see R12
      crit_locked |=> crit_locked && $stable(crit_limit))
      else $error("critical limit changed after lock");
   a_crit_locked_out: assert property ( // see R11
      wr_crit && !crit_unlock |=> $stable(crit_limit))
      else $error("critical limit changed without unlock");

   c_one_shot: cover property (hold_mode ##1 conv_single);
   c_crit_change: cover property (crit_accept ##1 crit_locked);
   c_alert_out: cover property (!alert_tach_oe ##1 alert_tach_oe);
   c_irq_raise: cover property (!irq ##1 irq);
endmodule // tfc_config
`default_nettype wire

// *** core/tfc_pkg.sv ***
/*
 * constants of the thermal fan configuration block: register offsets,
 * field positions, values after reset and interrupt status layout.
 * assumes an 8-bit register port and 8-bit two's complement temperatures.
 */
`default_nettype none
package tfc_pkg;
   // register offsets on the 8-bit register port
   localparam logic [7:0] TFC_ADDR_CONFIG = 8'h03;
   localparam logic [7:0] TFC_ADDR_CONFIG_ALT = 8'h09;
   localparam logic [7:0] TFC_ADDR_ONE_SHOT = 8'h0F;
   localparam logic [7:0] TFC_ADDR_CRIT_LIMIT = 8'h19;
   localparam logic [7:0] TFC_ADDR_HIGH_SETPOINT = 8'h40;
   localparam logic [7:0] TFC_ADDR_LOW_SETPOINT = 8'h41;
   localparam logic [7:0] TFC_ADDR_FAN_CONTROL = 8'h42;
   localparam logic [7:0] TFC_ADDR_IRQ_STATUS = 8'h60;
   localparam logic [7:0] TFC_ADDR_IRQ_ENABLE = 8'h61;
   localparam logic [7:0] TFC_ADDR_IRQ_CLEAR = 8'h62;

   // device_configuration field positions
   localparam int TFC_CFG_ALERT_MASK = 7;
   localparam int TFC_CFG_HOLD = 6;
   localparam int TFC_CFG_FAN_OFF_IN_HOLD = 5;
   localparam int TFC_CFG_TACH_SELECT = 2;
   localparam int TFC_CFG_CRIT_UNLOCK = 1;
   localparam int TFC_CFG_FAULT_FILTER = 0;
   // bits that exist; 4:3 are unused and read as zero
   localparam logic [7:0] TFC_CFG_WRITABLE = 8'hE7;

   // fan_control field: modulation output polarity
   localparam int TFC_FAN_POLARITY = 0;

   // interrupt status layout
   localparam int TFC_IRQ_CONV_DONE = 0;
   localparam int TFC_IRQ_FAULT = 1;
   localparam int TFC_IRQ_CRIT = 2;
   localparam int TFC_IRQ_CRIT_WRITTEN = 3;
   localparam int TFC_IRQ_WIDTH = 4;

   // values after reset
   localparam logic [7:0] TFC_CONFIG_RESET = 8'h00;
   localparam logic [7:0] TFC_CRIT_LIMIT_RESET = 8'h55; // 85 degrees
   localparam logic [7:0] TFC_HIGH_SETPOINT_RESET = 8'h7F;
   localparam logic [7:0] TFC_LOW_SETPOINT_RESET = 8'h00;
   localparam logic [7:0] TFC_FAN_CONTROL_RESET = 8'h00;
   localparam logic [7:0] TFC_READ_ZERO = 8'h00;

   // consecutive out-of-limit results needed in filtered mode
   localparam logic [1:0] TFC_FAULT_COUNT = 2'h3;
endpackage
`default_nettype wire

// *** core/tfc_fault_filter.sv ***
/*
 * remote_fault_filter: turns out-of-limit remote results into a fault
 * level, either on one result or on three consecutive ones.
 * assumes result_valid is a one-cycle pulse per remote conversion.
 */
`timescale 1ns/1ps
`default_nettype none
module tfc_fault_filter (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic result_valid,
   input wire logic out_of_limit,
   input wire logic three_mode,
   output logic fault
);
   import tfc_pkg::*;

   logic [1:0] run_count;
   logic [1:0] next_run_count;
   logic next_fault;

   // saturating count of consecutive out-of-limit results
   assign next_run_count = !out_of_limit ? 2'h0 : // see R15
      (run_count == TFC_FAULT_COUNT) ? run_count : run_count + 2'h1;
   // single mode trips on one result, filtered mode needs three
   assign next_fault = three_mode ?
      (next_run_count == TFC_FAULT_COUNT) : out_of_limit; // see R13 R14

   // fault only moves on a result, so it is a stable level between results
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         run_count <= 2'h0;
         fault <= 1'b0;
      end else if (result_valid) begin
         run_count <= next_run_count;
         fault <= next_fault;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_single_trip: assert property ( // see R13
      result_valid && out_of_limit && !three_mode |=> fault)
      else $error("single result did not raise fault");
   a_three_needed: assert property ( // see R14
      result_valid && three_mode && run_count < 2'h2 |=> !fault)
      else $error("filtered fault raised too early");
   // the third outside result in a row must trip, not only be allowed to
   a_three_trip: assert property ( // see R14
      result_valid && three_mode && out_of_limit && run_count >= 2'h2
      |=> fault)
      else $error("third outside result did not raise fault");
   a_count_restart: assert property ( // see R15
      result_valid && !out_of_limit |=> run_count == 2'h0 && !fault)
      else $error("in-range result did not restart count");
   c_three_trip: cover property (three_mode && !fault ##1 fault);
endmodule // tfc_fault_filter
`default_nettype wire

// *** verif/tfc_host_model.sv ***
/*
 * register port host model: one-cycle write and read strobes, read data
 * taken in the cycle after the strobe edge.
 * assumes the device never makes the host wait.
 */
`timescale 1ns/1ps
`default_nettype none
module tfc_host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [7:0] reg_rdata
);
   // idle bus from time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   // one-shot and critical limit writes use this too
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_addr <= ~a; // released bus shows no stale address
      reg_wdata <= ~d;
   endtask
   // data stands only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule // tfc_host_model
`default_nettype wire

// *** verif/thermal_fan_config_register_tb.sv ***
/*
 * self-checking bench of the configuration register bank: register
 * reads and writes through the host model, stimulus on the conversion,
 * fan and pin inputs.
 * assumes the shared pin is pulled up outside the device.
 */
`timescale 1ns/1ps
`default_nettype none
module thermal_fan_config_register_tb;
   import tfc_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic conv_done = 1'b0;
   logic [7:0] remote_temp = 8'h00;
   logic fan_wave = 1'b0;
   logic tach_drv = 1'b1;
   wire logic [7:0] reg_addr, reg_wdata;
   wire logic reg_write, reg_read, alert_tach_in;
   logic [7:0] reg_rdata;
   logic conv_run, conv_single, fan_out, alert_tach_out, alert_tach_oe;
   logic tach_pulse_in, crit_over, irq;
   int error_cnt = 0;
   int checks_done = 0;
   logic [7:0] seq_t [6] = '{8'h60, 8'h60, 8'h20, 8'h60, 8'h60, 8'h60};
   logic seq_e [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   // 200 MHz clock
   always #2.5 clk = ~clk;
   // pull-up wins unless the device pulls low
   assign alert_tach_in = alert_tach_oe ? 1'b0 : tach_drv;
   tfc_host_model host_u (.clk(clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata));
   tfc_config dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .conv_done(conv_done),
      .remote_temp(remote_temp), .conv_run(conv_run),
      .conv_single(conv_single), .fan_wave(fan_wave), .fan_out(fan_out),
      .alert_tach_in(alert_tach_in), .alert_tach_out(alert_tach_out),
      .alert_tach_oe(alert_tach_oe), .tach_pulse_in(tach_pulse_in),
      .crit_over(crit_over), .irq(irq));
   // verdict and end of run, shared with the watchdog
   task automatic final_report();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         $display("unexpected %s: expected %h, seen %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         $display("unexpected %s: expected %b, seen %b", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host_u.rd(a, d);
      chk8($sformatf("reg %h", a), e, d);
   endtask
   // pass n edges, then look once outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one remote result; alert pin settles two cycles after the pulse
   task automatic conv(input logic [7:0] t);
      @(posedge clk);
      conv_done <= 1'b1;
      remote_temp <= t;
      @(posedge clk);
      conv_done <= 1'b0;
      remote_temp <= ~t;
      cyc(2);
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      cyc(1);
   endtask
   // hang guard, far beyond the few hundred cycles of the tests
   initial begin
      #50000;
      error_cnt++;
      final_report();
   end
   // main sequence
   initial begin
      do_reset();
      chk1("conv_run", 1'b1, conv_run); // converting after reset
      rdchk(TFC_ADDR_CONFIG, 8'h00);
      rdchk(TFC_ADDR_CRIT_LIMIT, 8'h55); // 85 degrees
      rdchk(8'h20, 8'h00); // unmapped place reads zero
      host_u.wr(TFC_ADDR_CONFIG, 8'hFF);
      rdchk(TFC_ADDR_CONFIG_ALT, 8'hE7); // unused bits zero
      host_u.wr(TFC_ADDR_CONFIG_ALT, 8'h18);
      rdchk(TFC_ADDR_CONFIG, 8'h00); // only unused bits written
      // single-result alerts and pin function
      host_u.wr(TFC_ADDR_HIGH_SETPOINT, 8'h50);
      host_u.wr(TFC_ADDR_LOW_SETPOINT, 8'h10);
      conv(8'h60);
      chk1("alert_oe", 1'b1, alert_tach_oe); // over high
      chk1("alert_out", 1'b0, alert_tach_out); // pulls low only
      conv(8'h20);
      chk1("alert_oe", 1'b0, alert_tach_oe); // in range
      conv(8'hF0);
      chk1("alert_oe", 1'b1, alert_tach_oe); // below low
      host_u.wr(TFC_ADDR_CONFIG, 8'h80);
      cyc(2);
      chk1("alert_oe", 1'b0, alert_tach_oe); // masked pin open
      host_u.wr(TFC_ADDR_CONFIG, 8'h04);
      cyc(2);
      chk1("alert_oe", 1'b0, alert_tach_oe); // tach pin silent
      chk1("tach_in", 1'b1, tach_pulse_in); // pin follows
      @(posedge clk);
      tach_drv <= 1'b0;
      cyc(2);
      chk1("tach_in", 1'b0, tach_pulse_in); // pin follows
      @(posedge clk);
      tach_drv <= 1'b1;
      host_u.wr(TFC_ADDR_CONFIG, 8'h00);
      cyc(2);
      chk1("alert_oe", 1'b1, alert_tach_oe); // alert pin again
      chk1("tach_in", 1'b0, tach_pulse_in); // pin not tach
      // three in a row, restarted by an in-range result
      host_u.wr(TFC_ADDR_CONFIG, 8'h01);
      conv(8'h20);
      for (int i = 0; i < 6; i++) begin
         conv(seq_t[i]);
         chk1("alert_oe", seq_e[i], alert_tach_oe); // filter
      end
      // hold, single conversion and fan output
      host_u.wr(TFC_ADDR_CONFIG, 8'h00);
      host_u.wr(TFC_ADDR_ONE_SHOT, 8'hA5);
      #1 chk1("conv_single", 1'b0, conv_single); // not in hold
      host_u.wr(TFC_ADDR_CONFIG, 8'h40);
      cyc(2);
      chk1("conv_run", 1'b0, conv_run); // hold stops runs
      host_u.wr(TFC_ADDR_ONE_SHOT, 8'h3C);
      #1 chk1("conv_single", 1'b1, conv_single); // one shot
      cyc(1);
      chk1("conv_single", 1'b0, conv_single); // a single pulse
      @(posedge clk);
      fan_wave <= 1'b1;
      cyc(2);
      chk1("fan_out", 1'b1, fan_out); // wave kept in hold
      host_u.wr(TFC_ADDR_CONFIG, 8'h60);
      cyc(2);
      chk1("fan_out", 1'b0, fan_out); // disabled level low
      host_u.wr(TFC_ADDR_FAN_CONTROL, 8'h01);
      @(posedge clk);
      fan_wave <= 1'b0;
      cyc(2);
      chk1("fan_out", 1'b1, fan_out); // disabled level high
      host_u.wr(TFC_ADDR_CONFIG, 8'h20);
      cyc(2);
      chk1("fan_out", 1'b0, fan_out); // running again
      chk1("conv_run", 1'b1, conv_run); // running again
      // one-time critical limit
      host_u.wr(TFC_ADDR_CONFIG, 8'h00);
      host_u.wr(TFC_ADDR_CRIT_LIMIT, 8'h33);
      rdchk(TFC_ADDR_CRIT_LIMIT, 8'h55); // locked without bit 1
      host_u.wr(TFC_ADDR_CONFIG, 8'h02);
      host_u.wr(TFC_ADDR_CRIT_LIMIT, 8'h40);
      rdchk(TFC_ADDR_CRIT_LIMIT, 8'h40); // first change taken
      host_u.wr(TFC_ADDR_CRIT_LIMIT, 8'h30);
      rdchk(TFC_ADDR_CRIT_LIMIT, 8'h40); // second refused
      host_u.wr(TFC_ADDR_CONFIG, 8'h00);
      host_u.wr(TFC_ADDR_CONFIG, 8'h02);
      host_u.wr(TFC_ADDR_CRIT_LIMIT, 8'h20);
      rdchk(TFC_ADDR_CRIT_LIMIT, 8'h40); // re-unlock no help
      do_reset();
      rdchk(TFC_ADDR_CRIT_LIMIT, 8'h55); // power cycle restores
      // interrupt raised, masked and cleared
      conv(8'h60);
      chk1("crit_over", 1'b1, crit_over); // above 85 degrees
      rdchk(TFC_ADDR_IRQ_STATUS, 8'h05); // done, over limit
      host_u.wr(TFC_ADDR_IRQ_CLEAR, 8'h0F);
      host_u.wr(TFC_ADDR_IRQ_ENABLE, 8'h01);
      conv(8'h20);
      chk1("irq", 1'b1, irq);
      rdchk(TFC_ADDR_IRQ_STATUS, 8'h01);
      host_u.wr(TFC_ADDR_IRQ_ENABLE, 8'h00);
      cyc(2);
      chk1("irq", 1'b0, irq);
      host_u.wr(TFC_ADDR_IRQ_ENABLE, 8'h01);
      host_u.wr(TFC_ADDR_IRQ_CLEAR, 8'h01);
      cyc(2);
      chk1("irq", 1'b0, irq);
      rdchk(TFC_ADDR_IRQ_STATUS, 8'h00);
      final_report();
   end
endmodule // thermal_fan_config_register_tb
`default_nettype wire
